// file: osd_host_serial_pkg.sv
// Purpose: Constants shared by the host serial command port.
// Assumes: System clock of 10 MHz.
// Notes:   Counts are derived from the printed rates.
`default_nettype none
package osd_host_serial_pkg;
  // ----------------------------------------------------------------
  // Clock and link rates
  // ----------------------------------------------------------------
  localparam int unsigned MCLK_HZ         = 10_000_000;
  localparam int unsigned I2C_MAX_HZ      = 400_000;
  localparam int unsigned THREE_WIRE_MAX_HZ = 1_000_000;
  // Least number of system clocks in one link bit period.
  localparam int unsigned I2C_BIT_CYC     = MCLK_HZ / I2C_MAX_HZ;
  localparam int unsigned THREE_WIRE_BIT_CYC = MCLK_HZ / THREE_WIRE_MAX_HZ;
  // ----------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR       = 7'h5D;
  localparam logic [3:0] I2C_BYTE_BITS    = 4'h8;
  localparam logic [2:0] THREE_WIRE_LAST_BIT = 3'h7;
  localparam int unsigned COMMAND_COUNT   = 16;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SHIFT_RESET      = 8'h00;
  localparam logic [5:0] SYNC_RESET       = 6'h00;
endpackage
`default_nettype wire

// file: osd_host_serial_port.sv
// Purpose: Receive-only host command port with I2C and three-wire front ends.
// Assumes: Sync inputs are already polarity corrected, active high.
// Notes:   All pins except test_mode and ram_byte_next pass two flip-flops before use.
`timescale 1ns/1ps
`default_nettype none
module osd_host_serial_port
  import osd_host_serial_pkg::*;
(
  // System
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Mode pins
  input  wire logic       port_select,
  input  wire logic       test_mode,
  input  wire logic       chip_enable,
  // Shared data pin: I2C data or three_wire_data_in
  input  wire logic       data_pin_in,
  output logic            data_pin_out,
  output logic            data_pin_oe,
  // Shared clock pin
  input  wire logic       clk_pin_in,
  output logic            clk_pin_out,
  output logic            clk_pin_oe,
  // Video timing
  input  wire logic       hsync_active,
  input  wire logic       vsync_active,
  // Command interpreter
  input  wire logic       ram_byte_next,
  output logic            cmd_valid,
  output logic            ram_write,
  output logic [7:0]      cmd_byte,
  output logic            bus_error
);
  import osd_host_serial_pkg::*;

  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_DATA, I_STALL, I_ACK, I_READ, I_IGNORE
  } i2c_state_e;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [5:0] prev;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= SYNC_RESET;
      sync2 <= SYNC_RESET;
      prev  <= SYNC_RESET;
    end else begin
      sync1 <= {port_select, chip_enable, clk_pin_in, data_pin_in, hsync_active, vsync_active};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  logic sel_i2c;
  logic ce;
  logic sck;
  logic sda;
  logic window;
  logic ce_rise;
  logic sck_rise;
  logic sck_fall;
  logic start_det;
  logic stop_det;

  assign sel_i2c   = sync2[5];
  assign ce        = sync2[4];
  assign sck       = sync2[3];
  assign sda       = sync2[2];
  assign window    = sync2[1] & ~sync2[0];
  assign ce_rise   = ce & ~prev[4];
  assign sck_rise  = sck & ~prev[3];
  assign sck_fall  = ~sck & prev[3];
  assign start_det = sel_i2c & sck & prev[3] & ~sda & prev[2];
  assign stop_det  = sel_i2c & sck & prev[3] & sda & ~prev[2];

  // ----------------------------------------------------------------
  // I2C slave receiver
  // ----------------------------------------------------------------
  i2c_state_e st;
  logic [3:0] cnt;
  logic [7:0] shift;
  logic       i2c_cmd;
  logic       i2c_ram;
  logic       addr_ok;
  logic       byte_end;
  logic       read_req;

  assign addr_ok  = (shift[7:1] == SLAVE_ADDR) && (!shift[0] || test_mode);
  assign byte_end = sck_fall && (cnt == I2C_BYTE_BITS);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st           <= I_IDLE;
      cnt          <= 4'h0;
      shift        <= SHIFT_RESET;
      data_pin_oe  <= 1'b0;
      clk_pin_oe   <= 1'b0;
      i2c_cmd      <= 1'b0;
      i2c_ram      <= 1'b0;
      bus_error    <= 1'b0;
      read_req     <= 1'b0;
    end else begin
      i2c_cmd   <= 1'b0;
      i2c_ram   <= 1'b0;
      bus_error <= 1'b0;
      if (!sel_i2c) begin
        st          <= I_IDLE;
        cnt         <= 4'h0;
        data_pin_oe <= 1'b0;
        clk_pin_oe  <= 1'b0;
      end else if (start_det || stop_det) begin
        // The first clock of a legal STOP or repeated START shifts one bit.
        bus_error   <= (st == I_ADDR || st == I_DATA) && cnt > 4'h1;
        st          <= start_det ? I_ADDR : I_IDLE;
        cnt         <= 4'h0;
        shift       <= SHIFT_RESET;
        data_pin_oe <= 1'b0;
        clk_pin_oe  <= 1'b0;
      end else begin
        unique case (st)
          I_IDLE, I_IGNORE, I_READ: begin
            data_pin_oe <= 1'b0;
          end
          I_ADDR, I_DATA: begin
            if (sck_rise && cnt != I2C_BYTE_BITS) begin
              shift <= {shift[6:0], sda};
              cnt   <= cnt + 4'h1;
            end else if (byte_end) begin
              cnt <= 4'h0;
              if (st == I_ADDR) begin
                st          <= addr_ok ? I_ACK : I_IGNORE;
                read_req    <= shift[0];
                data_pin_oe <= addr_ok;
              end else if (ram_byte_next && !window) begin
                st         <= I_STALL;
                clk_pin_oe <= 1'b1;
              end else begin
                st          <= I_ACK;
                data_pin_oe <= 1'b1;
                i2c_cmd     <= !ram_byte_next;
                i2c_ram     <= ram_byte_next;
              end
            end
          end
          I_STALL: begin
            if (window) begin
              clk_pin_oe  <= 1'b0;
              i2c_ram     <= 1'b1;
              data_pin_oe <= 1'b1;
              st          <= I_ACK;
            end
          end
          I_ACK: begin
            if (sck_fall) begin
              data_pin_oe <= 1'b0;
              st          <= read_req ? I_READ : I_DATA;
            end
          end
        endcase
      end
    end
  end

  assign data_pin_out = 1'b0;
  assign clk_pin_out  = 1'b0;

  // ----------------------------------------------------------------
  // Three-wire receiver
  // ----------------------------------------------------------------
  logic [7:0] hshift;
  logic [2:0] hcnt;
  logic       h_done;

  assign h_done = !sel_i2c && ce && !ce_rise && sck_rise && hcnt == THREE_WIRE_LAST_BIT;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hshift <= SHIFT_RESET;
      hcnt   <= 3'h0;
    end else if (sel_i2c || !ce) begin
      hcnt <= 3'h0;
    end else if (ce_rise) begin
      hshift <= SHIFT_RESET;
      hcnt   <= 3'h0;
    end else if (sck_rise) begin
      hshift <= {sda, hshift[7:1]};
      hcnt   <= hcnt + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Command interpreter hand-off
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmd_valid <= 1'b0;
      ram_write <= 1'b0;
      cmd_byte  <= SHIFT_RESET;
    end else begin
      cmd_valid <= h_done || i2c_cmd;
      ram_write <= i2c_ram;
      if (h_done) begin
        cmd_byte <= {sda, hshift[7:1]};
      end else if (i2c_cmd || i2c_ram) begin
        cmd_byte <= shift;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_select;
    !sel_i2c |=> !data_pin_oe && !clk_pin_oe;
  endproperty
  a_select: assert property (p_select) else $error("I2C pins driven while deselected");

  property p_addr;
    st == I_ADDR && byte_end && shift[7:1] != SLAVE_ADDR |=> !data_pin_oe && st == I_IGNORE;
  endproperty
  a_addr: assert property (p_addr) else $error("Wrong slave address acknowledged");

  property p_rw;
    st == I_ADDR && byte_end && shift[0] && !test_mode && !start_det && !stop_det
      |=> st == I_IGNORE;
  endproperty
  a_rw: assert property (p_rw) else $error("Read accepted outside test mode");

  property p_ack;
    st == I_DATA && byte_end && !ram_byte_next && !start_det && !stop_det
      |=> data_pin_oe ##1 cmd_valid;
  endproperty
  a_ack: assert property (p_ack) else $error("Command byte not acknowledged");

  property p_stop;
    stop_det |=> st == I_IDLE && !data_pin_oe && !clk_pin_oe;
  endproperty
  a_stop: assert property (p_stop) else $error("STOP did not end transfer");

  property p_err;
    bus_error |-> st == I_ADDR || st == I_IDLE;
  endproperty
  a_err: assert property (p_err) else $error("Bus error did not restart receiver");

  property p_commit;
    ram_write |-> $past(window, 2);
  endproperty
  a_commit: assert property (p_commit) else $error("RAM byte committed outside retrace");

  property p_stall;
    st == I_STALL && !window && sel_i2c |-> clk_pin_oe;
  endproperty
  a_stall: assert property (p_stall) else $error("Clock not held before hsync");

  property p_release;
    st == I_STALL && window && sel_i2c && !start_det && !stop_det
      |=> !clk_pin_oe ##1 ram_write;
  endproperty
  a_release: assert property (p_release) else $error("Release or write missing");

  property p_ce_rise;
    !sel_i2c && ce_rise |=> hcnt == 3'h0 && hshift == SHIFT_RESET;
  endproperty
  a_ce_rise: assert property (p_ce_rise) else $error("Enable edge did not clear");

  property p_ce_low;
    !ce |=> hcnt == 3'h0 && !h_done;
  endproperty
  a_ce_low: assert property (p_ce_low) else $error("Shift continued with enable low");

  property p_byte;
    h_done |=> cmd_valid && cmd_byte == {$past(sda), $past(hshift[7:1])};
  endproperty
  a_byte: assert property (p_byte) else $error("Three-wire byte not delivered");

endmodule // osd_host_serial_port
`default_nettype wire

// file: osd_host_master.sv
// Purpose: Microcontroller model that masters both serial front ends.
// Assumes: Both pins are open drain with pull-ups; a released line reads high.
// Notes:   Pins change only on the falling system clock edge.
`timescale 1ns/1ps
`default_nettype none
module osd_host_master (
  // System
  input  wire logic mclk,
  // Resolved pin levels
  input  wire logic sda,
  input  wire logic scl,
  // Master drive, high means released on m_sda and m_scl; m_ce and stuck active high
  output logic      m_sda,
  output logic      m_scl,
  output logic      m_ce,
  output logic      stuck
);
  // ----------------------------------------------------------------
  // Pin tasks
  // ----------------------------------------------------------------
  initial begin
    m_sda = 1'b1;
    m_scl = 1'b1;
    m_ce  = 1'b0;
    stuck = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Releases the clock and waits while the device stretches it.
  task automatic rise_scl();
    int i;
    m_scl = 1'b1;
    for (i = 0; i < 4000 && scl !== 1'b1; i++) tick(1);
    if (i == 4000) stuck = 1'b1;
  endtask
  // Bit period 32 system clocks, 312.5 kHz.
  task automatic i2c_start();
    m_sda = 1'b1;
    tick(8);
    rise_scl();
    tick(16);
    m_sda = 1'b0;
    tick(16);
    m_scl = 1'b0;
    tick(8);
  endtask
  task automatic i2c_stop();
    m_sda = 1'b0;
    tick(8);
    rise_scl();
    tick(16);
    m_sda = 1'b1;
    tick(16);
  endtask
  task automatic i2c_bits(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      m_sda = v[7-i];
      tick(8);
      rise_scl();
      tick(16);
      m_scl = 1'b0;
      tick(8);
    end
  endtask
  task automatic i2c_byte(input logic [7:0] v, output logic ack);
    i2c_bits(v, 8);
    m_sda = 1'b1;
    tick(8);
    rise_scl();
    tick(8);
    ack = ~sda;
    tick(8);
    m_scl = 1'b0;
    tick(8);
  endtask
  // Link period 800 ns; data set on the falling clock, LSB first.
  task automatic hio_bits(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      m_scl = 1'b0;
      m_sda = v[i];
      tick(4);
      m_scl = 1'b1;
      tick(4);
    end
    m_sda = ~m_sda;
  endtask
  task automatic hio_enable(input logic on);
    m_ce = on;
    tick(4);
  endtask
endmodule // osd_host_master
`default_nettype wire

// file: osd_host_serial_port_tb_top.sv
// Purpose: Self-checking bench for the host serial command port.
// Assumes: Design and master model compiled first.
// Notes:   Expected bytes are queued and popped by an output monitor.
`timescale 1ns/1ps
`default_nettype none
module osd_host_serial_port_tb_top;
  import osd_host_serial_pkg::*;
  logic        mclk = 1'b0;
  logic        nrst, port_select, test_mode, hsync_active, vsync_active, ram_byte_next;
  wire logic   sda, scl, m_sda, m_scl, m_ce, stuck;
  wire logic   data_pin_out, data_pin_oe, clk_pin_out, clk_pin_oe;
  wire logic   cmd_valid, ram_write, bus_error;
  wire logic [7:0] cmd_byte;
  logic [31:0] seed = 32'h0000_58d9;
  logic [9:0]  expq[$];
  logic [9:0]  exp_v;
  logic [7:0]  b;
  logic        ack;
  int          errors = 0;
  int          checked = 0;
  int          bus_errs = 0;
  localparam logic [9:0] ADDR_CASES [4] = '{10'h0_B8, 10'h0_BB, 10'h3_BB, 10'h0_3A};
  always #50 mclk = ~mclk;
  assign sda = m_sda & (data_pin_oe ? data_pin_out : 1'b1);
  assign scl = m_scl & (clk_pin_oe ? clk_pin_out : 1'b1);
  osd_host_serial_port osd_host_serial_port_i (.mclk(mclk), .nrst(nrst),
    .port_select(port_select), .test_mode(test_mode), .chip_enable(m_ce),
    .data_pin_in(sda), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
    .clk_pin_in(scl), .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
    .hsync_active(hsync_active), .vsync_active(vsync_active), .ram_byte_next(ram_byte_next),
    .cmd_valid(cmd_valid), .ram_write(ram_write), .cmd_byte(cmd_byte), .bus_error(bus_error));
  osd_host_master osd_host_master_i (.mclk(mclk), .sda(sda), .scl(scl), .m_sda(m_sda),
    .m_scl(m_scl), .m_ce(m_ce), .stuck(stuck));
  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check_flag(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic check_byte(input string n, input logic [9:0] e, input logic [9:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run();
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic i2c_write(input logic [7:0] v, input logic e);
    osd_host_master_i.i2c_byte(v, ack);
    check_flag("acknowledge", e, ack);
  endtask
  always @(negedge mclk) begin
    if (bus_error === 1'b1) bus_errs++;
    if (nrst === 1'b1 && (cmd_valid === 1'b1 || ram_write === 1'b1)) begin
      exp_v = (expq.size() > 0) ? expq.pop_front() : 10'h000;
      check_byte("output byte", exp_v, {1'b1, ram_write, cmd_byte});
    end
    if (port_select === 1'b0 && (data_pin_oe !== 1'b0 || clk_pin_oe !== 1'b0))
      check_flag("pin drive", 1'b0, 1'b1);
  end
  always @(posedge stuck) begin
    errors++;
    complete_run();
  end
  initial begin
    repeat (90000) @(negedge mclk);
    errors++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {nrst, port_select} = 2'b00;
    b = rnd();
    {test_mode, hsync_active, vsync_active, ram_byte_next} = b[3:0];
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    osd_host_master_i.tick(4);
    osd_host_master_i.hio_enable(1'b1);
    for (int k = 0; k < 2; k++) begin
      b = rnd();
      expq.push_back({2'b10, b});
      osd_host_master_i.hio_bits(b, 8);
    end
    osd_host_master_i.hio_bits(8'h05, 3);
    osd_host_master_i.hio_enable(1'b0);
    osd_host_master_i.hio_enable(1'b1);
    b = rnd();
    expq.push_back({2'b10, b});
    osd_host_master_i.hio_bits(b, 8);
    osd_host_master_i.hio_enable(1'b0);
    osd_host_master_i.i2c_start();
    i2c_write(8'hBA, 1'b0);
    osd_host_master_i.i2c_stop();
    {test_mode, hsync_active, vsync_active, ram_byte_next} = 4'h0;
    port_select = 1'b1;
    osd_host_master_i.i2c_start();
    i2c_write(8'hBA, 1'b1);
    for (int k = 0; k < COMMAND_COUNT; k++) begin
      b = rnd();
      b[7:4] = k[3:0];
      expq.push_back({2'b10, b});
      i2c_write(b, 1'b1);
    end
    osd_host_master_i.i2c_stop();
    for (int k = 0; k < 4; k++) begin
      test_mode = ADDR_CASES[k][9];
      osd_host_master_i.i2c_start();
      i2c_write(ADDR_CASES[k][7:0], ADDR_CASES[k][8]);
      if (!ADDR_CASES[k][8]) i2c_write(8'h33, 1'b0);
      osd_host_master_i.i2c_stop();
    end
    test_mode = 1'b0;
    osd_host_master_i.i2c_start();
    i2c_write(8'hBA, 1'b1);
    ram_byte_next = 1'b1;
    b = rnd();
    expq.push_back({2'b11, b});
    fork
      i2c_write(b, 1'b1);
      begin
        for (int i = 0; i < 400 && clk_pin_oe !== 1'b1; i++) osd_host_master_i.tick(1);
        check_flag("clock hold", 1'b1, clk_pin_oe);
        {hsync_active, vsync_active} = 2'b11;
        osd_host_master_i.tick(20);
        check_flag("clock hold", 1'b1, clk_pin_oe);
        vsync_active = 1'b0;
      end
    join
    b = rnd();
    expq.push_back({2'b11, b});
    i2c_write(b, 1'b1);
    {hsync_active, ram_byte_next} = 2'b00;
    osd_host_master_i.i2c_stop();
    osd_host_master_i.i2c_start();
    osd_host_master_i.i2c_bits(8'hA0, 3);
    osd_host_master_i.i2c_stop();
    osd_host_master_i.i2c_start();
    i2c_write(8'hBA, 1'b1);
    b = rnd();
    expq.push_back({2'b10, b});
    i2c_write(b, 1'b1);
    osd_host_master_i.i2c_stop();
    osd_host_master_i.tick(40);
    check_byte("bus errors", 10'd1, bus_errs[9:0]);
    check_byte("pending bytes", 10'd0, 10'(expq.size()));
    complete_run();
  end
endmodule // osd_host_serial_port_tb_top
`default_nettype wire
